/* rtl/crp_color_prox_regs.sv */
`include "crp_params.svh"

// Behaviour
// - Four 16-bit colour results, low/high byte pairs
// - Low-byte read copies high byte to shadow
// - Later conversions never disturb the shadowed high
// - Clear low read snapshots all 64 bits
// - Proximity result is unsigned byte at 0x9C
// - North/east offset register scales crosstalk correction
// - Offsets decode as sign and magnitude
// - South/west offset register scales crosstalk correction
// - Config register holds four diode mask bits
// - Mask bit one removes that diode
// - Single unmasked diode saturates at 127
// - Gain compensation bit doubles, max 255
// - Sleep after interrupt until interrupt cleared
// - Proximity result read clears proximity valid
// - Colour valid set per cycle, cleared on read
module crp_color_prox_regs (
  input  wire logic                clk,
  input  wire logic                sys_rst,
  input  wire logic [7:0]          reg_addr,
  input  wire logic                reg_wr,
  input  wire crp_pkg::crp_byte_t  reg_wdata,
  input  wire logic                reg_rd,
  output crp_pkg::crp_byte_t       reg_rdata,
  input  wire logic                colour_done,
  input  wire logic [15:0]         clear_data,
  input  wire logic [15:0]         red_data,
  input  wire logic [15:0]         green_data,
  input  wire logic [15:0]         blue_data,
  input  wire logic                prox_done,
  input  wire logic [6:0]          diode_n,
  input  wire logic [6:0]          diode_s,
  input  wire logic [6:0]          diode_w,
  input  wire logic [6:0]          diode_e,
  input  wire logic                int_asserted,
  input  wire logic                sai_decision,
  output logic                     colour_result_valid,
  output logic                     proximity_result_valid,
  output logic [3:0]               proximity_diode_mask,
  output logic                     low_power
);

  // ==========================================================
  // Storage
  logic [15:0]        live_q   [4];
  logic [15:0]        live_d   [4];
  logic [15:0]        shadow_q [4];
  logic [15:0]        shadow_d [4];
  logic [3:0]         lock_q;
  logic [3:0]         lock_d;
  logic [15:0]        colour_in [4];
  logic [3:0]         rd_low;
  logic [3:0]         rd_high;
  logic               colour_rd_any;
  logic               prox_rd;

  crp_pkg::crp_byte_t prox_q;
  crp_pkg::crp_byte_t prox_d;
  crp_pkg::crp_byte_t ne_off_q;
  crp_pkg::crp_byte_t ne_off_d;
  crp_pkg::crp_byte_t sw_off_q;
  crp_pkg::crp_byte_t sw_off_d;
  crp_pkg::crp_byte_t cfg_q;
  crp_pkg::crp_byte_t cfg_d;
  crp_pkg::crp_byte_t rdata_q;
  crp_pkg::crp_byte_t rdata_d;
  logic               cvalid_q;
  logic               cvalid_d;
  logic               proximity_result_valid_q;
  logic               proximity_result_valid_d;
  crp_pkg::crp_power_e power_q;
  crp_pkg::crp_power_e power_d;

  crp_prox_if prox_bus ();

  assign colour_in[0] = clear_data;
  assign colour_in[1] = red_data;
  assign colour_in[2] = green_data;
  assign colour_in[3] = blue_data;

  // ==========================================================
  // Per-channel address decode, channel 0 is clear
  for (genvar c = 0; c < 4; c++) begin : g_chan
    localparam logic [7:0] LOW_ADDR = `CRP_CLEAR_LOW_ADDR + 8'(2 * c);
    assign rd_low[c]  = reg_rd && (reg_addr == LOW_ADDR);
    assign rd_high[c] = reg_rd && (reg_addr == LOW_ADDR + 8'h01);
  end

  assign colour_rd_any = |{rd_low, rd_high};
  assign prox_rd       = reg_rd && (reg_addr == `CRP_PROX_RESULT_ADDR);

  // ==========================================================
  // Proximity front end
  assign prox_bus.mask      = cfg_q[3:0];
  assign prox_bus.gain_comp = cfg_q[`CRP_CFG_GAIN_BIT];
  assign prox_bus.ne_offset = ne_off_q;
  assign prox_bus.sw_offset = sw_off_q;
  assign prox_bus.diode_n   = diode_n;
  assign prox_bus.diode_s   = diode_s;
  assign prox_bus.diode_w   = diode_w;
  assign prox_bus.diode_e   = diode_e;

  crp_prox_front u_front (
    .p (prox_bus.front)
  );

  // ==========================================================
  // Live colour values, reloaded on every finished colour cycle
  always_comb begin
    for (int c = 0; c < 4; c++) begin
      live_d[c] = colour_done ? colour_in[c] : live_q[c];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int c = 0; c < 4; c++) begin
        live_q[c] <= 16'h0000;
      end
    end else begin
      live_q <= live_d;
    end
  end

  // ==========================================================
  // Colour shadows and snapshot locks
  always_comb begin
    lock_d = lock_q;
    for (int c = 0; c < 4; c++) begin
      shadow_d[c] = shadow_q[c];
    end
    if (rd_low[0]) begin
      // Whole snapshot taken at once keeps all channels coherent
      for (int c = 0; c < 4; c++) begin
        shadow_d[c] = live_q[c];
      end
      lock_d = 4'b1110;
    end else begin
      for (int c = 1; c < 4; c++) begin
        if (rd_low[c] && !lock_q[c]) begin
          shadow_d[c] = live_q[c];
        end
      end
    end
    // A high read releases the channel; shadow itself is kept
    for (int c = 1; c < 4; c++) begin
      if (rd_high[c]) begin
        lock_d[c] = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int c = 0; c < 4; c++) begin
        shadow_q[c] <= 16'h0000;
      end
      lock_q <= 4'h0;
    end else begin
      shadow_q <= shadow_d;
      lock_q   <= lock_d;
    end
  end

  // ==========================================================
  // Writable registers and proximity result
  always_comb begin
    ne_off_d = ne_off_q;
    sw_off_d = sw_off_q;
    cfg_d    = cfg_q;
    prox_d   = prox_done ? prox_bus.result : prox_q;
    if (reg_wr) begin
      if (reg_addr == `CRP_NE_OFFSET_ADDR) begin
        ne_off_d = reg_wdata;
      end else if (reg_addr == `CRP_SW_OFFSET_ADDR) begin
        sw_off_d = reg_wdata;
      end else if (reg_addr == `CRP_DIODE_CONFIG_ADDR) begin
        // Bits 7:6 are not stored and read back as zero
        cfg_d = reg_wdata & `CRP_CFG_WRITABLE_MASK;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ne_off_q <= `CRP_RESET_BYTE;
      sw_off_q <= `CRP_RESET_BYTE;
      cfg_q    <= `CRP_RESET_BYTE;
      prox_q   <= `CRP_RESET_BYTE;
    end else begin
      ne_off_q <= ne_off_d;
      sw_off_q <= sw_off_d;
      cfg_q    <= cfg_d;
      prox_q   <= prox_d;
    end
  end

  // ==========================================================
  // Colour valid; a new result wins over a clearing read
  always_comb begin
    cvalid_d = colour_done | (cvalid_q & ~colour_rd_any);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cvalid_q <= 1'b0;
    end else begin
      cvalid_q <= cvalid_d;
    end
  end

  // ==========================================================
  // Proximity valid; only its own result read clears it
  always_comb begin
    proximity_result_valid_d = prox_done | (proximity_result_valid_q & ~prox_rd);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      proximity_result_valid_q <= 1'b0;
    end else begin
      proximity_result_valid_q <= proximity_result_valid_d;
    end
  end

  // ==========================================================
  // Read data, answered one cycle after the strobe
  always_comb begin
    rdata_d = rdata_q;
    if (reg_rd) begin
      if (rd_low[0]) begin
        rdata_d = live_q[0][7:0];
      end else if (rd_low[1]) begin
        rdata_d = lock_q[1] ? shadow_q[1][7:0] : live_q[1][7:0];
      end else if (rd_low[2]) begin
        rdata_d = lock_q[2] ? shadow_q[2][7:0] : live_q[2][7:0];
      end else if (rd_low[3]) begin
        rdata_d = lock_q[3] ? shadow_q[3][7:0] : live_q[3][7:0];
      end else if (rd_high[0]) begin
        rdata_d = shadow_q[0][15:8];
      end else if (rd_high[1]) begin
        rdata_d = shadow_q[1][15:8];
      end else if (rd_high[2]) begin
        rdata_d = shadow_q[2][15:8];
      end else if (rd_high[3]) begin
        rdata_d = shadow_q[3][15:8];
      end else if (prox_rd) begin
        rdata_d = prox_q;
      end else if (reg_addr == `CRP_NE_OFFSET_ADDR) begin
        rdata_d = ne_off_q;
      end else if (reg_addr == `CRP_SW_OFFSET_ADDR) begin
        rdata_d = sw_off_q;
      end else if (reg_addr == `CRP_DIODE_CONFIG_ADDR) begin
        rdata_d = cfg_q;
      end else begin
        rdata_d = `CRP_UNMAPPED_BYTE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_q <= `CRP_RESET_BYTE;
    end else begin
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================
  // Sleep after interrupt: wait at the decision point until cleared
  always_comb begin
    power_d = power_q;
    case (power_q)
      crp_pkg::CRP_RUN: begin
        if (cfg_q[`CRP_CFG_SAI_BIT] && int_asserted && sai_decision) begin
          power_d = crp_pkg::CRP_SLEEP;
        end
      end
      crp_pkg::CRP_SLEEP: begin
        if (!int_asserted) begin
          power_d = crp_pkg::CRP_RUN;
        end
      end
      default: power_d = crp_pkg::CRP_RUN;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      power_q <= crp_pkg::CRP_RUN;
    end else begin
      power_q <= power_d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata              = rdata_q;
  assign colour_result_valid    = cvalid_q;
  assign proximity_result_valid = proximity_result_valid_q;
  assign proximity_diode_mask   = cfg_q[3:0];
  assign low_power              = (power_q == crp_pkg::CRP_SLEEP);

endmodule

/* rtl/crp_params.svh */
`ifndef CRP_PARAMS_SVH
`define CRP_PARAMS_SVH

// ==========================================================
// Register offsets
`define CRP_CLEAR_LOW_ADDR     8'h94
`define CRP_CLEAR_HIGH_ADDR    8'h95
`define CRP_RED_LOW_ADDR       8'h96
`define CRP_RED_HIGH_ADDR      8'h97
`define CRP_GREEN_LOW_ADDR     8'h98
`define CRP_GREEN_HIGH_ADDR    8'h99
`define CRP_BLUE_LOW_ADDR      8'h9A
`define CRP_BLUE_HIGH_ADDR     8'h9B
`define CRP_PROX_RESULT_ADDR   8'h9C
`define CRP_NE_OFFSET_ADDR     8'h9D
`define CRP_SW_OFFSET_ADDR     8'h9E
`define CRP_DIODE_CONFIG_ADDR  8'h9F

// ==========================================================
// Field positions in the diode configuration register
`define CRP_CFG_EAST_BIT       0
`define CRP_CFG_WEST_BIT       1
`define CRP_CFG_SOUTH_BIT      2
`define CRP_CFG_NORTH_BIT      3
`define CRP_CFG_SAI_BIT        4
`define CRP_CFG_GAIN_BIT       5
`define CRP_CFG_WRITABLE_MASK  8'h3F

// ==========================================================
// Reset and answer values
`define CRP_RESET_BYTE         8'h00
`define CRP_UNMAPPED_BYTE      8'h00
`define CRP_RESULT_MAX         10'h0FF

`endif

/* rtl/crp_pkg.sv */
package crp_pkg;

  // ==========================================================
  // Types
  typedef logic [7:0] crp_byte_t;

  typedef enum logic {
    CRP_RUN,
    CRP_SLEEP
  } crp_power_e;

endpackage

/* rtl/crp_prox_front.sv */
`include "crp_params.svh"

module crp_prox_front (
  crp_prox_if.front p
);

  // ==========================================================
  // Sign/magnitude offset to two's complement
  function automatic logic signed [10:0] sm_to_signed(input logic [7:0] v);
    logic signed [10:0] mag;
    mag = signed'({4'h0, v[6:0]});
    sm_to_signed = v[7] ? -mag : mag;
  endfunction

  logic        [8:0] ne_sum;
  logic        [8:0] sw_sum;
  logic signed [10:0] ne_corr;
  logic signed [10:0] sw_corr;
  logic       [9:0] total;
  logic       [9:0] scaled;

  // ==========================================================
  // Masked pair sums, crosstalk correction, gain and clamp
  always_comb begin
    ne_sum = (p.mask[`CRP_CFG_NORTH_BIT] ? 9'h000 : {2'b00, p.diode_n})
           + (p.mask[`CRP_CFG_EAST_BIT]  ? 9'h000 : {2'b00, p.diode_e});
    sw_sum = (p.mask[`CRP_CFG_SOUTH_BIT] ? 9'h000 : {2'b00, p.diode_s})
           + (p.mask[`CRP_CFG_WEST_BIT]  ? 9'h000 : {2'b00, p.diode_w});
    // Positive factor removes crosstalk; a pair never goes below zero
    ne_corr = signed'({2'b00, ne_sum}) - sm_to_signed(p.ne_offset);
    sw_corr = signed'({2'b00, sw_sum}) - sm_to_signed(p.sw_offset);
    if (ne_corr < 0) begin
      ne_corr = '0;
    end
    if (sw_corr < 0) begin
      sw_corr = '0;
    end
    total  = 10'(ne_corr) + 10'(sw_corr);
    // One diode alone reaches 127; doubling restores full scale
    scaled = p.gain_comp ? {total[8:0], 1'b0} : total;
    // Top bit lost in the doubling would wrap; it means saturation
    if ((p.gain_comp && total[9]) || (scaled > `CRP_RESULT_MAX)) begin
      p.result = 8'hFF;
    end else begin
      p.result = scaled[7:0];
    end
  end

endmodule

/* rtl/crp_prox_if.sv */
interface crp_prox_if;
  logic       [3:0] mask;        // N,S,W,E at 3..0, one excludes a diode
  logic             gain_comp;
  crp_pkg::crp_byte_t ne_offset;
  crp_pkg::crp_byte_t sw_offset;
  logic       [6:0] diode_n;
  logic       [6:0] diode_s;
  logic       [6:0] diode_w;
  logic       [6:0] diode_e;
  crp_pkg::crp_byte_t result;

  modport front (
    input  mask, gain_comp, ne_offset, sw_offset,
    input  diode_n, diode_s, diode_w, diode_e,
    output result
  );

  modport bank (
    output mask, gain_comp, ne_offset, sw_offset,
    output diode_n, diode_s, diode_w, diode_e,
    input  result
  );
endinterface

/* tb/crp_color_prox_regs_bench.sv */
// ==========================================================
// Bench
module crp_color_prox_regs_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, sys_rst, reg_wr, reg_rd, colour_done, prox_done, int_asserted, sai_decision;
  logic colour_result_valid, proximity_result_valid, low_power;
  logic [7:0]         reg_addr;
  crp_pkg::crp_byte_t reg_wdata, reg_rdata, d;
  logic [15:0]        clear_data, red_data, green_data, blue_data;
  logic [6:0]         diode_n, diode_s, diode_w, diode_e;
  logic [3:0]         proximity_diode_mask;
  logic [7:0]         snap [6] = '{8'h78, 8'h56, 8'hBC, 8'h9A, 8'hF0, 8'hDE};
  int                 error_cnt = 0, samples_checked = 0, cyc = 0;

  crp_color_prox_regs DUT (.clk, .sys_rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
    .reg_rdata, .colour_done, .clear_data, .red_data, .green_data, .blue_data, .prox_done,
    .diode_n, .diode_s, .diode_w, .diode_e, .int_asserted, .sai_decision,
    .colour_result_valid, .proximity_result_valid, .proximity_diode_mask, .low_power);
  crp_host u_host (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);

  // Clock, 40 ns
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Hang guard, well above the roughly 120 cycles the run needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
    u_host.rd(a, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask
  task automatic setcol(input logic [15:0] c, r, g, b);
    {clear_data, red_data, green_data, blue_data} = {c, r, g, b};
    @(negedge clk) colour_done = 1'b1;
    @(negedge clk) colour_done = 1'b0;
  endtask
  // One proximity cycle with given settings and diode levels
  task automatic prox(input logic [7:0] cfg, ne, sw, input logic [6:0] n, s, w, e,
                      input logic [7:0] exp);
    u_host.wr(8'h9F, cfg);
    u_host.wr(8'h9D, ne);
    u_host.wr(8'h9E, sw);
    {diode_n, diode_s, diode_w, diode_e} = {n, s, w, e};
    @(negedge clk) prox_done = 1'b1;
    @(negedge clk) prox_done = 1'b0;
    chk("prox valid", 8'h01, {7'h0, proximity_result_valid});
    rdc(8'h9C, exp);
    chk("prox valid", 8'h00, {7'h0, proximity_result_valid});
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Main sequence
  initial begin
    {sys_rst, colour_done, prox_done, int_asserted, sai_decision} = 5'b10000;
    {clear_data, red_data, green_data, blue_data} = 64'h0;
    {diode_n, diode_s, diode_w, diode_e} = 28'h0;
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 3; i++) rdc(8'h9D + i, 8'h00);
    rdc(8'h95, 8'h00);
    rdc(8'h93, 8'h00);
    u_host.wr(8'h9D, 8'h85);
    rdc(8'h9D, 8'h85);
    u_host.wr(8'h9E, 8'hFF);
    rdc(8'h9E, 8'hFF);
    u_host.wr(8'h9F, 8'h3F);
    rdc(8'h9F, 8'h3F);
    chk("mask", 8'h0F, {4'h0, proximity_diode_mask});
    u_host.wr(8'h9C, 8'h55);
    rdc(8'h9C, 8'h00);
    // Colour pairs, with fresh results landing mid-pair
    setcol(16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0);
    chk("colour valid", 8'h01, {7'h0, colour_result_valid});
    rdc(8'h94, 8'h34);
    chk("colour valid", 8'h00, {7'h0, colour_result_valid});
    setcol(16'hA1B2, 16'hC3D4, 16'hE5F6, 16'h0718);
    rdc(8'h95, 8'h12);
    for (int i = 0; i < 6; i++) rdc(8'h96 + i, snap[i]);
    rdc(8'h97, 8'h56);
    rdc(8'h96, 8'hD4);
    rdc(8'h97, 8'hC3);
    // Proximity: saturation, masking, gain, offsets both signs
    prox(8'h00, 8'h00, 8'h00, 7'd100, 7'd50, 7'd60, 7'd100, 8'hFF);
    prox(8'h07, 8'h00, 8'h00, 7'd127, 7'd127, 7'd127, 7'd127, 8'h7F);
    prox(8'h27, 8'h00, 8'h00, 7'd127, 7'd127, 7'd127, 7'd127, 8'hFE);
    prox(8'h00, 8'h0A, 8'h85, 7'd20, 7'd10, 7'd10, 7'd30, 8'h41);
    prox(8'h0C, 8'hFF, 8'h7F, 7'd9, 7'd3, 7'd4, 7'd8, 8'h87);
    // Sleep only with the enable set, wake once interrupt drops
    for (int en = 0; en < 2; en++) begin
      u_host.wr(8'h9F, {3'b000, en[0], 4'h0});
      @(negedge clk) {int_asserted, sai_decision} = 2'b11;
      @(negedge clk) sai_decision = 1'b0;
      chk("low power", {7'h0, en[0]}, {7'h0, low_power});
      @(negedge clk) int_asserted = 1'b0;
      repeat (2) @(negedge clk);
      chk("low power", 8'h00, {7'h0, low_power});
    end
    print_verdict();
  end
endmodule

/* tb/crp_color_prox_regs_checker.sv */
// ==========================================================
// Port checker
module crp_color_prox_regs_checker (
  input wire logic               clk,
  input wire logic               sys_rst,
  input wire logic [7:0]         reg_addr,
  input wire logic               reg_wr,
  input wire crp_pkg::crp_byte_t reg_wdata,
  input wire logic               reg_rd,
  input wire crp_pkg::crp_byte_t reg_rdata,
  input wire logic               colour_done,
  input wire logic               prox_done,
  input wire logic               int_asserted,
  input wire logic               sai_decision,
  input wire logic               colour_result_valid,
  input wire logic               proximity_result_valid,
  input wire logic [3:0]         proximity_diode_mask,
  input wire logic               low_power
);
  timeunit 1ns;
  timeprecision 1ns;
  logic sai_q;
  logic sai_d;
  // Own copy of the sleep enable, so a stuck bit inside shows up
  always_comb begin
    sai_d = sai_q;
    if (reg_wr && reg_addr == 8'h9F) sai_d = reg_wdata[4];
  end
  // Registered mirror
  always_ff @(posedge clk) begin
    if (sys_rst) sai_q <= 1'b0;
    else sai_q <= sai_d;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  property p_mask;
    reg_wr && reg_addr == 8'h9F |=> proximity_diode_mask == $past(reg_wdata[3:0]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not taken");
  property p_rsv;
    reg_rd && reg_addr == 8'h9F |=> reg_rdata[7:6] == 2'b00;
  endproperty
  a_rsv: assert property (p_rsv) else $error("config top bits set");
  property p_pset;
    prox_done |=> proximity_result_valid;
  endproperty
  a_pset: assert property (p_pset) else $error("prox valid not set");
  property p_pclr;
    reg_rd && reg_addr == 8'h9C && !prox_done |=> !proximity_result_valid;
  endproperty
  a_pclr: assert property (p_pclr) else $error("prox valid not cleared");
  property p_cset;
    colour_done |=> colour_result_valid;
  endproperty
  a_cset: assert property (p_cset) else $error("colour valid not set");
  property p_cclr;
    reg_rd && reg_addr inside {[8'h94:8'h9B]} && !colour_done |=> !colour_result_valid;
  endproperty
  a_cclr: assert property (p_cclr) else $error("colour valid not cleared");
  property p_sleep;
    sai_q && int_asserted && sai_decision |=> low_power;
  endproperty
  a_sleep: assert property (p_sleep) else $error("no sleep");
  property p_wake;
    low_power && !int_asserted |=> !low_power;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_cause;
    $rose(low_power) |-> $past(int_asserted) && $past(sai_q);
  endproperty
  a_cause: assert property (p_cause) else $error("sleep without cause");
endmodule

bind crp_color_prox_regs crp_color_prox_regs_checker u_chk (.clk, .sys_rst, .reg_addr,
  .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .colour_done, .prox_done, .int_asserted,
  .sai_decision, .colour_result_valid, .proximity_result_valid, .proximity_diode_mask,
  .low_power);

/* tb/crp_host.sv */
// ==========================================================
// Host side of the register bus
module crp_host (
  input  wire logic               clk,
  input  wire crp_pkg::crp_byte_t reg_rdata,
  output logic [7:0]              reg_addr,
  output logic                    reg_wr,
  output crp_pkg::crp_byte_t      reg_wdata,
  output logic                    reg_rd
);
  timeunit 1ns;
  timeprecision 1ns;
  // Idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
  end
  // Byte write; data scrambled after release so nothing leans on it
  task automatic wr(input logic [7:0] a, input crp_pkg::crp_byte_t v);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = (a == 8'h9F) ? {2'b00, v[5:0]} : v;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_wdata = ~reg_wdata;
  endtask
  // Byte read; answer is registered, taken one cycle on
  task automatic rd(input logic [7:0] a, output crp_pkg::crp_byte_t v);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    v = reg_rdata;
  endtask
endmodule
